// ---- lpw_power_ctrl.v ----
`timescale 1ns/1ns
`include "lpw_defs.vh"
// Contract
// - Regulator has main, low-power and power-down modes for run, stop, standby.
// - Regulator enabled after reset; standby turns it off and powers core down.
// - Sleep halts only the processor; any interrupt or event resumes it.
// - Stop gates core clocks, disables PLL and both fast oscillators, retains state.
// - In stop the regulator uses main or low-power mode as configured.
// - Any external line edge (16 pins, detector, alarm) leaves stop; code needs a selected edge on a line set in imask_q or emask_q.
// - Standby switches off core domain, fast oscillators and PLL.
// - Standby exits on reset pin, watchdog reset, wakeup pin rise or alarm.
// - Stop and standby never halt clock calendar, watchdog or their clocks.
// - Supply reset holds the device in reset while supply is below threshold.
// - Supply detector interrupts on falling, rising, or both crossings.
// - Line event block has 19 edge-detector lines, interrupt or event each.
// - Each line has its own rising/falling selection and mask.
// - Detected triggers are recorded in a software-readable pending register.
// - Pulses shorter than a clock period are captured asynchronously.
// - After reset the processor runs from the internal 8 MHz RC oscillator.
// - External clock failure switches back to internal RC and may interrupt.
module lpw_power_ctrl #(
  parameter LINES = 19
) (
  clock,
  reset,
  reg_addr,
  reg_wdata,
  reg_write,
  reg_read,
  reg_rdata,
  lp_req,
  lp_req_code,
  any_irq_in,
  line_in,
  detector_level,
  alarm_in,
  wakeup_pin,
  reset_pin_n,
  watchdog_reset,
  supply_low,
  ext_osc_fail,
  cpu_clock_en,
  core_clock_en,
  pll_en,
  int_osc_en,
  ext_osc_en,
  rtc_clock_en,
  watchdog_clock_en,
  regulator_mode,
  core_power_on,
  sys_clock_sel_ext,
  device_reset,
  line_irq,
  line_event,
  clock_fail_irq,
  power_state
);
  input  wire              clock;
  input  wire              reset;
  input  wire [7:0]        reg_addr;
  input  wire [31:0]       reg_wdata;
  input  wire              reg_write;
  input  wire              reg_read;
  output reg  [31:0]       reg_rdata;
  input  wire              lp_req;
  input  wire [1:0]        lp_req_code;
  input  wire              any_irq_in;
  input  wire [15:0]       line_in;
  input  wire              detector_level;
  input  wire              alarm_in;
  input  wire              wakeup_pin;
  input  wire              reset_pin_n;
  input  wire              watchdog_reset;
  input  wire              supply_low;
  input  wire              ext_osc_fail;
  output wire              cpu_clock_en;
  output wire              core_clock_en;
  output wire              pll_en;
  output wire              int_osc_en;
  output wire              ext_osc_en;
  output wire              rtc_clock_en;
  output wire              watchdog_clock_en;
  output reg  [1:0]        regulator_mode;
  output wire              core_power_on;
  output wire              sys_clock_sel_ext;
  output wire              device_reset;
  output wire [LINES-1:0]  line_irq;
  output wire [LINES-1:0]  line_event;
  output wire              clock_fail_irq;
  output wire [1:0]        power_state;

  reg  [1:0]        state_q;
  reg  [1:0]        state_d;
  reg  [2:0]        ctrl_q;
  reg  [LINES-1:0]  rise_q;
  reg  [LINES-1:0]  fall_q;
  reg  [LINES-1:0]  imask_q;
  reg  [LINES-1:0]  emask_q;
  wire [LINES-1:0]  pend_q;
  reg               sel_ext_q;
  reg               fail_q;
  reg  [2:0]        sync_q [0:4];
  reg  [1:0]        sup_s_q;
  reg               wk_last_q;
  wire [LINES-1:0]  raw;
  wire [LINES-1:0]  hit;
  wire [LINES-1:0]  clr;
  wire              fail_s;
  wire              wk_s;
  wire              rst_pin_s;
  wire              wk_rise;
  wire              standby_exit;

  // Supply reset: level of the supply comparator, two-flop synchronised
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      sup_s_q <= 2'h3;
    end else begin
      sup_s_q <= {sup_s_q[0], supply_low};
    end
  end
  assign device_reset = reset | sup_s_q[1];

  // Line sources: 16 pins, gated detector, alarm
  assign raw = {1'b0, alarm_in, detector_level & ctrl_q[`LPW_CTRL_DET_EN],
                line_in};

  // Per-line asynchronous edge catchers
  genvar g;
  generate
    for (g = 0; g < LINES; g = g + 1) begin : gen_line
      reg rcap_q;
      reg fcap_q;
      reg [1:0] rs_q;
      reg [1:0] fs_q;
      reg rs_last_q;
      reg fs_last_q;
      reg pend_bit_q;
      // Pulses narrower than a clock period still toggle these flops
      always @(posedge raw[g] or posedge reset) begin
        if (reset) begin
          rcap_q <= 1'b0;
        end else begin
          rcap_q <= ~rcap_q;
        end
      end
      always @(negedge raw[g] or posedge reset) begin
        if (reset) begin
          fcap_q <= 1'b0;
        end else begin
          fcap_q <= ~fcap_q;
        end
      end
      always @(posedge clock or posedge reset) begin
        if (reset) begin
          rs_q      <= 2'h0;
          fs_q      <= 2'h0;
          rs_last_q <= 1'b0;
          fs_last_q <= 1'b0;
        end else begin
          rs_q      <= {rs_q[0], rcap_q};
          fs_q      <= {fs_q[0], fcap_q};
          rs_last_q <= rs_q[1];
          fs_last_q <= fs_q[1];
        end
      end
      assign hit[g] = (rise_q[g] & (rs_q[1] ^ rs_last_q)) |
                      (fall_q[g] & (fs_q[1] ^ fs_last_q));
      // Write one to clear; a new hit wins
      assign clr[g] = reg_write & (reg_addr == `LPW_ADDR_PEND) & reg_wdata[g];
      always @(posedge clock or posedge reset) begin
        if (reset) begin
          pend_bit_q <= 1'b0;
        end else if (hit[g]) begin
          pend_bit_q <= 1'b1;
        end else if (clr[g]) begin
          pend_bit_q <= 1'b0;
        end
      end
      assign pend_q[g] = pend_bit_q;
    end
  endgenerate
  assign line_irq   = pend_q & imask_q;
  assign line_event = hit & emask_q;

  // Synchronisers for standby wake sources, oscillator fail and detector status level
  integer i;
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      for (i = 0; i < 5; i = i + 1) begin
        sync_q[i] <= 3'h0;
      end
      wk_last_q <= 1'b0;
    end else begin
      sync_q[0] <= {sync_q[0][1:0], wakeup_pin};
      sync_q[1] <= {sync_q[1][1:0], ~reset_pin_n | watchdog_reset};
      sync_q[2] <= {sync_q[2][1:0], ext_osc_fail};
      sync_q[3] <= {sync_q[3][1:0], alarm_in};
      sync_q[4] <= {sync_q[4][1:0], detector_level};
      wk_last_q <= wk_s;
    end
  end
  assign wk_s      = sync_q[0][1];
  assign rst_pin_s = sync_q[1][1];
  assign fail_s    = sync_q[2][1];
  assign wk_rise   = wk_s & ~wk_last_q;
  assign standby_exit = rst_pin_s | wk_rise | sync_q[3][1];

  // Power state machine
  always @* begin
    state_d = state_q;
    case (state_q)
      `LPW_ST_RUN: begin
        if (lp_req) begin
          case (lp_req_code)
            `LPW_REQ_SLEEP:   state_d = `LPW_ST_SLEEP;
            `LPW_REQ_STOP:    state_d = `LPW_ST_STOP;
            `LPW_REQ_STANDBY: state_d = `LPW_ST_STANDBY;
            default:          state_d = `LPW_ST_RUN;
          endcase
        end
      end
      `LPW_ST_SLEEP: begin
        if (any_irq_in | (|line_irq) | (|line_event)) begin
          state_d = `LPW_ST_RUN;
        end
      end
      `LPW_ST_STOP: begin
        if (|(hit & (imask_q | emask_q))) begin
          state_d = `LPW_ST_RUN;
        end
      end
      `LPW_ST_STANDBY: begin
        if (standby_exit) begin
          state_d = `LPW_ST_RUN;
        end
      end
      default: state_d = `LPW_ST_RUN;
    endcase
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      state_q <= `LPW_ST_RUN;
    end else if (device_reset) begin
      state_q <= `LPW_ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // Regulator mode per state
  always @* begin
    case (state_q)
      `LPW_ST_STOP:    regulator_mode = ctrl_q[`LPW_CTRL_STOP_LPR] ?
                                        `LPW_REG_LOWPOWER : `LPW_REG_MAIN;
      `LPW_ST_STANDBY: regulator_mode = `LPW_REG_OFF;
      default:         regulator_mode = `LPW_REG_MAIN;
    endcase
  end

  wire in_stop    = (state_q == `LPW_ST_STOP);
  wire in_standby = (state_q == `LPW_ST_STANDBY);
  assign power_state       = state_q;
  assign cpu_clock_en      = (state_q == `LPW_ST_RUN);
  assign core_clock_en     = ~in_stop & ~in_standby;
  assign pll_en            = core_clock_en;
  assign int_osc_en        = core_clock_en;
  assign ext_osc_en        = core_clock_en & sel_ext_q;
  assign core_power_on     = ~in_standby;
  assign rtc_clock_en      = 1'b1;
  assign watchdog_clock_en = 1'b1;
  assign sys_clock_sel_ext = sel_ext_q;
  assign clock_fail_irq    = fail_q & ctrl_q[`LPW_CTRL_FAIL_IE];

  // Register writes, clock select and failure flag
  wire wr_clk = reg_write & (reg_addr == `LPW_ADDR_CLK);
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      ctrl_q    <= 3'h0;
      rise_q    <= {LINES{1'b0}};
      fall_q    <= {LINES{1'b0}};
      imask_q   <= {LINES{1'b0}};
      emask_q   <= {LINES{1'b0}};
      sel_ext_q <= 1'b0;
      fail_q    <= 1'b0;
    end else begin
      if (reg_write) begin
        case (reg_addr)
          `LPW_ADDR_CTRL:  ctrl_q  <= reg_wdata[2:0];
          `LPW_ADDR_RISE:  rise_q  <= reg_wdata[LINES-1:0];
          `LPW_ADDR_FALL:  fall_q  <= reg_wdata[LINES-1:0];
          `LPW_ADDR_IMASK: imask_q <= reg_wdata[LINES-1:0];
          `LPW_ADDR_EMASK: emask_q <= reg_wdata[LINES-1:0];
          default: ;
        endcase
      end
      if (sel_ext_q & fail_s) begin
        sel_ext_q <= 1'b0;
      end else if (in_stop | in_standby) begin
        sel_ext_q <= 1'b0;
      end else if (wr_clk) begin
        sel_ext_q <= reg_wdata[`LPW_CLK_SEL_EXT];
      end
      if (sel_ext_q & fail_s) begin
        fail_q <= 1'b1;
      end else if (wr_clk & reg_wdata[`LPW_CLK_FAIL]) begin
        fail_q <= 1'b0;
      end
    end
  end

  // Read data, one cycle after the strobe
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_read) begin
      case (reg_addr)
        `LPW_ADDR_CTRL:   reg_rdata <= {29'h0000_0000, ctrl_q};
        `LPW_ADDR_STATUS: reg_rdata <= {29'h0000_0000, sync_q[4][1] &
                                        ctrl_q[`LPW_CTRL_DET_EN], state_q};
        `LPW_ADDR_RISE:   reg_rdata <= {{(32-LINES){1'b0}}, rise_q};
        `LPW_ADDR_FALL:   reg_rdata <= {{(32-LINES){1'b0}}, fall_q};
        `LPW_ADDR_IMASK:  reg_rdata <= {{(32-LINES){1'b0}}, imask_q};
        `LPW_ADDR_EMASK:  reg_rdata <= {{(32-LINES){1'b0}}, emask_q};
        `LPW_ADDR_PEND:   reg_rdata <= {{(32-LINES){1'b0}}, pend_q};
        `LPW_ADDR_CLK:    reg_rdata <= {30'h0000_0000, fail_q, sel_ext_q};
        default:          reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end
endmodule // lpw_power_ctrl

// ---- lpw_defs.vh ----
`ifndef LPW_DEFS_VH
`define LPW_DEFS_VH
// Register addresses (byte offsets, 32-bit words)
`define LPW_ADDR_CTRL     8'h00
`define LPW_ADDR_STATUS   8'h04
`define LPW_ADDR_RISE     8'h08
`define LPW_ADDR_FALL     8'h0C
`define LPW_ADDR_IMASK    8'h10
`define LPW_ADDR_EMASK    8'h14
`define LPW_ADDR_PEND     8'h18
`define LPW_ADDR_CLK      8'h1C
// Control register fields
`define LPW_CTRL_STOP_LPR 0
`define LPW_CTRL_DET_EN   1
`define LPW_CTRL_FAIL_IE  2
// Clock register fields
`define LPW_CLK_SEL_EXT   0
`define LPW_CLK_FAIL      1
// Line indices in the line event block
`define LPW_LINE_DET      16
`define LPW_LINE_ALARM    17
// Power states
`define LPW_ST_RUN        2'h0
`define LPW_ST_SLEEP      2'h1
`define LPW_ST_STOP       2'h2
`define LPW_ST_STANDBY    2'h3
// Regulator modes
`define LPW_REG_MAIN      2'h0
`define LPW_REG_LOWPOWER  2'h1
`define LPW_REG_OFF       2'h2
// Low-power request codes
`define LPW_REQ_SLEEP     2'h1
`define LPW_REQ_STOP      2'h2
`define LPW_REQ_STANDBY   2'h3
`endif

// ---- lpw_power_ctrl_props.sv ----
`timescale 1ns/1ns
`include "lpw_defs.vh"
module lpw_props (
  input wire       clock,
  input wire       reset,
  input wire       lp_req,
  input wire [1:0] lp_req_code,
  input wire       ext_osc_fail,
  input wire       supply_low,
  input wire       cpu_clock_en,
  input wire       core_clock_en,
  input wire       pll_en,
  input wire       int_osc_en,
  input wire       ext_osc_en,
  input wire       rtc_clock_en,
  input wire       watchdog_clock_en,
  input wire [1:0] regulator_mode,
  input wire       core_power_on,
  input wire       sys_clock_sel_ext,
  input wire       device_reset,
  input wire [1:0] power_state
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  property p_run_reg;
    power_state == `LPW_ST_RUN |-> regulator_mode == `LPW_REG_MAIN;
  endproperty
  a_run_reg: assert property (p_run_reg) else $error("run regulator");
  property p_sleep;
    power_state == `LPW_ST_SLEEP |-> !cpu_clock_en && core_clock_en;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep clocks");
  property p_stop_clk;
    power_state == `LPW_ST_STOP |-> !(core_clock_en || pll_en || int_osc_en || ext_osc_en);
  endproperty
  a_stop_clk: assert property (p_stop_clk) else $error("stop clocks");
  property p_stop_reg;
    power_state == `LPW_ST_STOP |-> regulator_mode inside {`LPW_REG_MAIN, `LPW_REG_LOWPOWER};
  endproperty
  a_stop_reg: assert property (p_stop_reg) else $error("stop regulator");
  property p_stby;
    power_state == `LPW_ST_STANDBY |-> regulator_mode == `LPW_REG_OFF && !core_power_on && !pll_en;
  endproperty
  a_stby: assert property (p_stby) else $error("standby power");
  property p_free_clk;
    rtc_clock_en && watchdog_clock_en;
  endproperty
  a_free_clk: assert property (p_free_clk) else $error("calendar clock");
  property p_req;
    power_state == `LPW_ST_RUN && lp_req && !device_reset |=> power_state == $past(lp_req_code);
  endproperty
  a_req: assert property (p_req) else $error("request entry");
  property p_stay;
    power_state == `LPW_ST_RUN && !lp_req |=> power_state == `LPW_ST_RUN;
  endproperty
  a_stay: assert property (p_stay) else $error("spurious entry");
  property p_fail;
    sys_clock_sel_ext && ext_osc_fail |-> ##[1:4] !sys_clock_sel_ext;
  endproperty
  a_fail: assert property (p_fail) else $error("clock fail-over");
  property p_supply;
    supply_low |-> ##[0:3] device_reset;
  endproperty
  a_supply: assert property (p_supply) else $error("supply reset");
  c_sleep: cover property (power_state == `LPW_ST_SLEEP);
  c_stop: cover property (power_state == `LPW_ST_STOP);
  c_stby: cover property (power_state == `LPW_ST_STANDBY);
endmodule // lpw_props
bind lpw_power_ctrl lpw_props i_props (
  .clock, .reset, .lp_req, .lp_req_code, .ext_osc_fail, .supply_low, .cpu_clock_en,
  .core_clock_en, .pll_en, .int_osc_en, .ext_osc_en, .rtc_clock_en, .watchdog_clock_en,
  .regulator_mode, .core_power_on, .sys_clock_sel_ext, .device_reset, .power_state
);

// ---- lpw_src.sv ----
`timescale 1ns/1ns
module lpw_src (
  output logic [21:0] src_q
);
  // Reset pin idles high, every other source idles low
  initial src_q = 22'h08_0000;
  task automatic pulse(input int idx, input int wid);
    src_q[idx] = ~src_q[idx];
    #wid;
    src_q[idx] = ~src_q[idx];
  endtask
endmodule // lpw_src

// ---- lpw_tb.sv ----
`timescale 1ns/1ns
`include "lpw_defs.vh"
`define CHK(a, b) \
  begin \
    check_count++; \
    if ((a) !== (b)) begin \
      mismatches++; \
      $display("wrong value at %0t: %h vs %h", $time, (a), (b)); \
    end \
  end
module testbench;
  logic        clock = 1'h0;
  logic        reset = 1'h1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_write = 1'h0;
  logic        reg_read = 1'h0;
  logic        lp_req = 1'h0;
  logic [1:0]  lp_req_code = 2'h0;
  logic        any_irq_in = 1'h0;
  logic        supply_low = 1'h0;
  int          mismatches = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          ev_count = 0;
  wire  [21:0] src;
  wire  [31:0] reg_rdata;
  wire  [18:0] line_irq;
  wire  [18:0] line_event;
  wire  [1:0]  regulator_mode;
  wire  [1:0]  power_state;
  wire         cpu_clock_en, core_clock_en, pll_en, int_osc_en, ext_osc_en, rtc_clock_en;
  wire         watchdog_clock_en, core_power_on, sys_clock_sel_ext, device_reset, clock_fail_irq;
  lpw_src i_src (.src_q(src));
  lpw_power_ctrl i_dut (
    .clock, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .lp_req,
    .lp_req_code, .any_irq_in, .line_in(src[15:0]), .detector_level(src[16]),
    .alarm_in(src[17]), .wakeup_pin(src[18]), .reset_pin_n(src[19]),
    .watchdog_reset(src[20]), .supply_low, .ext_osc_fail(src[21]), .cpu_clock_en,
    .core_clock_en, .pll_en, .int_osc_en, .ext_osc_en, .rtc_clock_en, .watchdog_clock_en,
    .regulator_mode, .core_power_on, .sys_clock_sel_ext, .device_reset, .line_irq,
    .line_event, .clock_fail_irq, .power_state
  );
  initial forever #5 clock = ~clock;
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      report_and_stop();
    end
  end
  // Counts one-cycle event pulses as the design samples them
  always @(posedge clock) begin
    if (|line_event) ev_count++;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'h1;
    @(posedge clock);
    reg_write <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'h1;
    @(posedge clock);
    reg_read <= 1'h0;
    #1;
    `CHK(reg_rdata, e)
  endtask
  task automatic wst(input logic [1:0] s);
    for (int i = 0; i < 20 && power_state !== s; i++) @(posedge clock);
    #1;
    `CHK(power_state, s)
  endtask
  task automatic req(input logic [1:0] c);
    @(posedge clock);
    lp_req <= 1'h1;
    lp_req_code <= c;
    @(posedge clock);
    lp_req <= 1'h0;
    wst(c);
  endtask
  task automatic fire(input int idx, input int wid);
    #1;
    i_src.pulse(idx, wid);
    repeat (6) @(posedge clock);
    #1;
  endtask
  initial begin
    repeat (20) @(posedge clock);
    reset <= 1'h0;
    repeat (4) @(posedge clock);
    #1;
    `CHK({cpu_clock_en, core_clock_en, regulator_mode, sys_clock_sel_ext}, 5'h18)
    rd(`LPW_ADDR_CLK, 32'h0000_0000);
    rd(8'h40, 32'h0000_0000);
    wr(`LPW_ADDR_RISE, 32'h0000_0005);
    wr(`LPW_ADDR_FALL, 32'h0000_0002);
    wr(`LPW_ADDR_IMASK, 32'h0000_0001);
    #1;
    for (int i = 0; i < 4; i++) i_src.pulse(i, 3);
    repeat (6) @(posedge clock);
    #1;
    `CHK(line_irq, 19'h0_0001)
    rd(`LPW_ADDR_PEND, 32'h0000_0007);
    wr(`LPW_ADDR_PEND, 32'h0000_0007);
    rd(`LPW_ADDR_PEND, 32'h0000_0000);
    wr(`LPW_ADDR_RISE, 32'h0003_0020);
    wr(`LPW_ADDR_IMASK, 32'h0003_0020);
    fire(16, 3);
    rd(`LPW_ADDR_PEND, 32'h0000_0000);
    wr(`LPW_ADDR_CTRL, 32'h0000_0002);
    fire(16, 3);
    rd(`LPW_ADDR_PEND, 32'h0001_0000);
    wr(`LPW_ADDR_PEND, 32'h0001_0000);
    wr(`LPW_ADDR_EMASK, 32'h0000_0020);
    fire(5, 3);
    `CHK(ev_count, 32'h0000_0001)
    wr(`LPW_ADDR_PEND, 32'h0000_0020);
    req(`LPW_REQ_SLEEP);
    `CHK({cpu_clock_en, core_clock_en}, 2'h1)
    @(posedge clock) any_irq_in <= 1'h1;
    wst(`LPW_ST_RUN);
    @(posedge clock) any_irq_in <= 1'h0;
    for (int k = 0; k < 3; k++) begin
      wr(`LPW_ADDR_CTRL, 32'h0000_0002 | (k & 1));
      wr(`LPW_ADDR_CLK, 32'h0000_0001);
      req(`LPW_REQ_STOP);
      `CHK({core_clock_en, pll_en, int_osc_en, ext_osc_en}, 4'h0)
      `CHK({rtc_clock_en, watchdog_clock_en}, 2'h3)
      `CHK(regulator_mode, k[0] ? `LPW_REG_LOWPOWER : `LPW_REG_MAIN)
      fire(k == 0 ? 5 : 15 + k, 3);
      wst(`LPW_ST_RUN);
      `CHK(sys_clock_sel_ext, 1'h0)
      wr(`LPW_ADDR_PEND, 32'h0003_0020);
    end
    for (int k = 17; k < 21; k++) begin
      req(`LPW_REQ_STANDBY);
      `CHK({regulator_mode, core_power_on, core_clock_en, pll_en}, 5'h10)
      fire(k, 30);
      wst(`LPW_ST_RUN);
    end
    wr(`LPW_ADDR_CTRL, 32'h0000_0004);
    wr(`LPW_ADDR_CLK, 32'h0000_0001);
    rd(`LPW_ADDR_CLK, 32'h0000_0001);
    fire(21, 60);
    `CHK({sys_clock_sel_ext, clock_fail_irq}, 2'h1)
    rd(`LPW_ADDR_CLK, 32'h0000_0002);
    @(posedge clock) supply_low <= 1'h1;
    repeat (4) @(posedge clock);
    #1;
    `CHK(device_reset, 1'h1)
    @(posedge clock) supply_low <= 1'h0;
    repeat (4) @(posedge clock);
    #1;
    `CHK(device_reset, 1'h0)
    report_and_stop();
  end
endmodule // testbench
